// >>> dsm_regs.svh
// Purpose: timing constants and field positions for the switch mode control
// Assumes: 100 MHz clock
// Notes:   counts are derived from times in ns

`ifndef DSM_REGS_SVH
`define DSM_REGS_SVH

`define DSM_CLK_PERIOD_NS 10
`define DSM_STBY_DELAY_NS 1000000
`define DSM_RETRY_NS      2000000

// least times, rounded up to whole cycles
`define DSM_STBY_CYCLES \
  ((`DSM_STBY_DELAY_NS + `DSM_CLK_PERIOD_NS - 1) / `DSM_CLK_PERIOD_NS)
`define DSM_RETRY_CYCLES \
  ((`DSM_RETRY_NS + `DSM_CLK_PERIOD_NS - 1) / `DSM_CLK_PERIOD_NS)

// sense select pair {high, low}
`define DSM_SEL_CH1  2'h0
`define DSM_SEL_CH2  2'h1
`define DSM_SEL_TEMP 2'h2
`define DSM_SEL_NONE 2'h3

`define DSM_NUM_CH 2

`endif

// >>> dsm_pkg.sv
// Purpose: shared types of the switch mode control
// Assumes: nothing
// Notes:   fault is tracked per channel, not as a device mode

package dsm_pkg;

  typedef enum logic [2:0] {
    DSM_OFF,
    DSM_STANDBY,
    DSM_STBY_DELAY,
    DSM_DIAGNOSTIC,
    DSM_ACTIVE
  } dsm_mode_t;

  typedef enum logic [2:0] {
    DSM_SNS_HIZ,
    DSM_SNS_CH1_CUR,
    DSM_SNS_CH2_CUR,
    DSM_SNS_TEMP,
    DSM_SNS_FAULT,
    DSM_SNS_NONE
  } dsm_sense_t;

endpackage

// >>> dsm_chan.sv
// Purpose: one switch channel: fault shutdown, retry, open-load flag
// Assumes: inputs synchronous to clk_i
// Notes:   one instance per channel, no shared state

`timescale 1ns/1ps
`include "dsm_regs.svh"

module dsm_chan #(
  parameter int unsigned RETRY_CYCLES = `DSM_RETRY_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  input  wire logic powered_i,
  input  wire logic gnd_ok_i,
  input  wire logic enable_i,
  input  wire logic diag_i,
  input  wire logic latch_i,
  input  wire logic shutdown_i,
  input  wire logic open_load_i,
  output logic      switch_on_o,
  output logic      fault_o,
  output logic      open_load_o
);

  localparam int RW = $clog2(RETRY_CYCLES + 1);

  if (RETRY_CYCLES < 1) begin : g_chk
    $error("RETRY_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic          on;
    logic          fault;
    logic [RW-1:0] retry;
    logic          ol;
    logic          diag_d;
    logic          en_d;
  } dsm_chan_state_t;

  dsm_chan_state_t st;
  dsm_chan_state_t next_st;

  logic retry_done;
  logic leave;
  logic ol_clear;

  always_comb begin
    next_st    = st;
    retry_done = (st.retry == '0);
    leave      = st.fault & !shutdown_i & !latch_i & retry_done;
    ol_clear   = (st.diag_d & !diag_i) | (!st.en_d & enable_i);
    next_st.diag_d = diag_i;
    next_st.en_d   = enable_i;
    if (!powered_i) begin
      next_st.fault = 1'b0;
      next_st.retry = '0;
    end else if (shutdown_i) begin
      // a new shutdown always wins over a pending exit
      next_st.fault = 1'b1;
      next_st.retry = RW'(RETRY_CYCLES - 1);
    end else if (leave) begin
      next_st.fault = 1'b0;
    end else if (st.fault && !retry_done) begin
      next_st.retry = st.retry - 1'b1;
    end
    // switch follows only its own enable; ground loss forces off
    next_st.on = powered_i & gnd_ok_i & enable_i & !next_st.fault;
    // comparator status is tracked live while disabled with diagnostics on
    next_st.ol = powered_i & diag_i & !enable_i & open_load_i & !ol_clear;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign switch_on_o = st.on;
  assign fault_o     = st.fault;
  assign open_load_o = st.ol;

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  a_fault_entry: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i && powered_i && shutdown_i |=> fault_o && !switch_on_o)
    else $error("shutdown did not enter fault");

  a_fault_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i && powered_i && fault_o && (latch_i || !retry_done) |=> fault_o)
    else $error("fault left early");

  a_reenable_on: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i && powered_i && gnd_ok_i && leave && enable_i |=> !fault_o && switch_on_o)
    else $error("switch not re-enabled after fault");

  a_stay_off: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i && leave && !enable_i |=> !switch_on_o)
    else $error("switch on without enable");

  a_gnd_loss: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i && !gnd_ok_i |=> !switch_on_o)
    else $error("switch on while ground lost");

  a_ol_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i && (!diag_i || enable_i) |=> !open_load_o)
    else $error("open-load flag outside diagnostics");

  c_retry: cover property (@(posedge clk_i) disable iff (reset_i)
    fault_o ##1 !fault_o && switch_on_o);

endmodule // dsm_chan

// >>> dsm_ctrl.sv
// Purpose: operating-mode control of a dual high-side switch
// Assumes: inputs synchronous to clk_i; supply and ground status come
//          from analog monitors
// Notes:   sense_oe_o low means the sense pin floats

`timescale 1ns/1ps
`include "dsm_regs.svh"

// Functional notes
// - unpowered device sits in Off, no switching, no diagnostics
// - all enables and diagnostic enable low starts Standby Delay
// - at delay expiry go to Standby only if all inputs still low
// - Standby is lowest power with no diagnostics at all
// - Diagnostic mode runs diagnostics with both switches off
// - Active whenever at least one switch is enabled
// - diagnostics toggle freely in Active, independent of switches
// - thermal shutdown or current limit puts that channel in Fault
// - leave Fault when faults clear, latch low and retry timer expired
// - after Fault, switch back on if its enable is high
// - after Fault, switch stays off if its enable is low
// - each channel switches from its own enable only
// - a fault on one channel never touches the other
// - ground loss turns both switches off, off ones stay off
// - ground restored resumes normal operation by itself
// - inverse current is not detected and raises no fault
// - diagnostic enable low keeps sense output high impedance
// - fault on selected channel drives sense to fault level
// - open-load flag clears on diag falling or enable rising
// - open-load reported only while disabled with diagnostics on
module dsm_ctrl #(
  parameter int unsigned STBY_CYCLES  = `DSM_STBY_CYCLES,
  parameter int unsigned RETRY_CYCLES = `DSM_RETRY_CYCLES
) (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                ce_i,
  input  wire logic                supply_ok_i,
  input  wire logic                gnd_ok_i,
  input  wire logic                channel_one_enable_i,
  input  wire logic                channel_two_enable_i,
  input  wire logic                diagnostic_enable_i,
  input  wire logic                latch_select_i,
  input  wire logic                sense_select_high_i,
  input  wire logic                sense_select_low_i,
  input  wire logic [1:0]          thermal_shutdown_i,
  input  wire logic [1:0]          current_limit_i,
  input  wire logic [1:0]          open_load_detect_i,
  output dsm_pkg::dsm_mode_t       mode_o,
  output logic [1:0]               switch_on_o,
  output logic [1:0]               channel_fault_o,
  output logic [1:0]               open_load_o,
  output dsm_pkg::dsm_sense_t      sense_output_o,
  output logic                     sense_oe_o
);

  import dsm_pkg::*;

  // ------------------------------------------------
  // parameters and checks
  // ------------------------------------------------
  localparam int CW = $clog2(STBY_CYCLES + 1);

  if (STBY_CYCLES < 2) begin : g_chk
    $error("STBY_CYCLES must be at least 2");
  end

  // ------------------------------------------------
  // state
  // ------------------------------------------------
  typedef struct packed {
    dsm_mode_t     mode;
    logic [CW-1:0] stby_cnt;
    dsm_sense_t    sense;
    logic          sense_oe;
  } dsm_top_state_t;

  dsm_top_state_t st;
  dsm_top_state_t next_st;

  logic [1:0] ch_en;
  logic [1:0] ch_on;
  logic [1:0] ch_fault;
  logic [1:0] ch_ol;
  logic [1:0] fault_det;
  logic [1:0] sel;
  logic       any_en;
  logic       all_low;
  logic       diag_live;
  logic       stby_done;

  assign ch_en     = {channel_two_enable_i, channel_one_enable_i};
  assign sel       = {sense_select_high_i, sense_select_low_i};
  assign any_en    = |ch_en;
  assign all_low   = !any_en && !diagnostic_enable_i;
  // diagnostics exist only while powered; standby implies diag low
  assign diag_live = supply_ok_i && diagnostic_enable_i;
  assign stby_done = (st.stby_cnt == CW'(STBY_CYCLES - 1));

  // ------------------------------------------------
  // channels
  // ------------------------------------------------
  // no inverse-current input: the condition is invisible to the logic
  for (genvar i = 0; i < `DSM_NUM_CH; i++) begin : g_ch
    dsm_chan #(
      .RETRY_CYCLES (RETRY_CYCLES)
    ) u_chan (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .ce_i        (ce_i),
      .powered_i   (supply_ok_i),
      .gnd_ok_i    (gnd_ok_i),
      .enable_i    (ch_en[i]),
      .diag_i      (diag_live),
      .latch_i     (latch_select_i),
      .shutdown_i  (thermal_shutdown_i[i] | current_limit_i[i]),
      .open_load_i (open_load_detect_i[i]),
      .switch_on_o (ch_on[i]),
      .fault_o     (ch_fault[i]),
      .open_load_o (ch_ol[i])
    );

    assign fault_det[i] = ch_fault[i] | ch_ol[i];
  end

  // ------------------------------------------------
  // mode and sense mux
  // ------------------------------------------------
  always_comb begin
    next_st = st;

    if (!supply_ok_i) begin
      next_st.mode     = DSM_OFF;
      next_st.stby_cnt = '0;
    end else if (any_en) begin
      next_st.mode     = DSM_ACTIVE;
      next_st.stby_cnt = '0;
    end else if (diagnostic_enable_i) begin
      next_st.mode     = DSM_DIAGNOSTIC;
      next_st.stby_cnt = '0;
    end else begin
      unique case (st.mode)
        DSM_STANDBY: begin
          next_st.mode = DSM_STANDBY;
        end
        DSM_STBY_DELAY: begin
          if (stby_done) begin
            next_st.mode     = DSM_STANDBY;
            next_st.stby_cnt = '0;
          end else begin
            next_st.stby_cnt = st.stby_cnt + 1'b1;
          end
        end
        DSM_OFF, DSM_DIAGNOSTIC, DSM_ACTIVE: begin
          next_st.mode     = DSM_STBY_DELAY;
          next_st.stby_cnt = '0;
        end
      endcase
    end

    // sense follows inputs even in the mode-change cycle
    if (!diag_live) begin
      next_st.sense    = DSM_SNS_HIZ;
      next_st.sense_oe = 1'b0;
    end else begin
      next_st.sense_oe = 1'b1;
      unique case (sel)
        `DSM_SEL_CH1: begin
          next_st.sense = fault_det[0] ? DSM_SNS_FAULT : DSM_SNS_CH1_CUR;
        end
        `DSM_SEL_CH2: begin
          next_st.sense = fault_det[1] ? DSM_SNS_FAULT : DSM_SNS_CH2_CUR;
        end
        `DSM_SEL_TEMP: begin
          next_st.sense = DSM_SNS_TEMP;
        end
        `DSM_SEL_NONE: begin
          // undefined selection: leave the pin floating
          next_st.sense    = DSM_SNS_NONE;
          next_st.sense_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st.mode     <= DSM_OFF;
      st.stby_cnt <= '0;
      st.sense    <= DSM_SNS_HIZ;
      st.sense_oe <= 1'b0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------
  // outputs
  // ------------------------------------------------
  assign mode_o          = st.mode;
  assign sense_output_o  = st.sense;
  assign sense_oe_o      = st.sense_oe;
  assign switch_on_o     = ch_on;
  assign channel_fault_o = ch_fault;
  assign open_load_o     = ch_ol;

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (reset_i);

  a_off_unpowered: assert property (
    ce_i && !supply_ok_i |=> mode_o == DSM_OFF && switch_on_o == 2'h0 && !sense_oe_o)
    else $error("not off while unpowered");

  a_delay_entry: assert property (
    ce_i && supply_ok_i && all_low && mode_o != DSM_STANDBY
    && !(mode_o == DSM_STBY_DELAY && stby_done)
    |=> mode_o == DSM_STBY_DELAY)
    else $error("standby delay not entered");

  a_delay_expiry: assert property (
    ce_i && supply_ok_i && all_low && mode_o == DSM_STBY_DELAY && stby_done
    |=> mode_o == DSM_STANDBY)
    else $error("standby not reached at delay expiry");

  a_standby_cause: assert property (
    ce_i && mode_o == DSM_STBY_DELAY && !stby_done
    |=> mode_o != DSM_STANDBY)
    else $error("standby reached before delay expiry");

  a_standby_quiet: assert property (
    mode_o == DSM_STANDBY |-> !sense_oe_o && open_load_o == 2'h0)
    else $error("diagnostics alive in standby");

  a_diag_mode: assert property (
    ce_i && supply_ok_i && !any_en && diagnostic_enable_i
    |=> mode_o == DSM_DIAGNOSTIC && switch_on_o == 2'h0)
    else $error("diagnostic mode wrong");

  a_active_mode: assert property (
    ce_i && supply_ok_i && any_en |=> mode_o == DSM_ACTIVE)
    else $error("active mode not entered");

  a_delay_restart: assert property (
    ce_i && mode_o == DSM_STBY_DELAY && !all_low |=> st.stby_cnt == '0)
    else $error("standby delay not restarted");

  a_sense_hiz: assert property (
    ce_i && !diagnostic_enable_i |=> !sense_oe_o && sense_output_o == DSM_SNS_HIZ)
    else $error("sense driven with diagnostics off");

  a_sense_fault: assert property (
    ce_i && diag_live && sel == `DSM_SEL_CH1 && fault_det[0]
    |=> sense_oe_o && sense_output_o == DSM_SNS_FAULT)
    else $error("fault level missing on sense");

  a_ch_isolate: assert property (
    ce_i && supply_ok_i && gnd_ok_i && ch_en[1] && !thermal_shutdown_i[1]
    && !current_limit_i[1] && !ch_fault[1] && thermal_shutdown_i[0]
    |=> switch_on_o[1])
    else $error("fault on one channel disturbed the other");

  a_ch_isolate_rev: assert property (
    ce_i && supply_ok_i && gnd_ok_i && ch_en[0] && !thermal_shutdown_i[0]
    && !current_limit_i[0] && !ch_fault[0] && current_limit_i[1]
    |=> switch_on_o[0])
    else $error("fault on channel two disturbed channel one");

  a_sense_fault_two: assert property (
    ce_i && diag_live && sel == `DSM_SEL_CH2 && fault_det[1]
    |=> sense_oe_o && sense_output_o == DSM_SNS_FAULT)
    else $error("fault level missing on channel two sense");

  a_sense_temp: assert property (
    ce_i && diag_live && sel == `DSM_SEL_TEMP |=> sense_oe_o && sense_output_o == DSM_SNS_TEMP)
    else $error("temperature reading replaced");

  a_gnd_both_off: assert property (
    ce_i && !gnd_ok_i |=> switch_on_o == 2'h0)
    else $error("a switch stayed on after ground loss");

  a_diag_off_flags: assert property (
    ce_i && !diagnostic_enable_i |=> open_load_o == 2'h0)
    else $error("open-load flag without diagnostics");

  a_active_diag: assert property (
    ce_i && supply_ok_i && any_en && diagnostic_enable_i && sel != `DSM_SEL_NONE
    |=> mode_o == DSM_ACTIVE && sense_oe_o)
    else $error("diagnostics not available in active mode");

  a_delay_count: assert property (
    ce_i && supply_ok_i && all_low && mode_o == DSM_STBY_DELAY && !stby_done
    |=> mode_o == DSM_STBY_DELAY && st.stby_cnt == $past(st.stby_cnt) + 1'b1)
    else $error("standby delay did not advance");

  a_ce_freeze: assert property (
    !ce_i |=> $stable(mode_o) && $stable(switch_on_o) && $stable(channel_fault_o) && $stable(sense_output_o))
    else $error("state moved while clock enable low");

  // ------------------------------------------------
  // per-channel checks
  // ------------------------------------------------
  // both channels obey one contract; a loop keeps their checks from drifting apart
  for (genvar i = 0; i < `DSM_NUM_CH; i++) begin : g_chk_ch
    a_own_enable: assert property (
      ce_i && supply_ok_i && gnd_ok_i && !ch_fault[i] && !thermal_shutdown_i[i] && !current_limit_i[i]
      |=> switch_on_o[i] == $past(ch_en[i]))
      else $error("switch does not follow its own enable");

    a_fault_off: assert property (
      channel_fault_o[i] |-> !switch_on_o[i])
      else $error("switch on while its channel is in fault");

    a_latch_hold: assert property (
      ce_i && supply_ok_i && channel_fault_o[i] && latch_select_i |=> channel_fault_o[i])
      else $error("latched fault released");

    a_ol_track: assert property (
      ce_i && diag_live && !ch_en[i] && open_load_detect_i[i] |=> open_load_o[i])
      else $error("open load not reported");

    a_ol_drop: assert property (
      ce_i && !open_load_detect_i[i] |=> !open_load_o[i])
      else $error("open-load flag outlived its cause");

    a_ol_switch_on: assert property (
      open_load_o[i] |-> !switch_on_o[i])
      else $error("open load reported on an enabled switch");

    a_supply_clears: assert property (
      ce_i && !supply_ok_i |=> !channel_fault_o[i] && !open_load_o[i])
      else $error("channel state kept while unpowered");
  end

  c_standby: cover property (mode_o == DSM_STBY_DELAY ##1 mode_o == DSM_STANDBY);

  c_sense_fault: cover property (sense_output_o == DSM_SNS_FAULT);

  c_both_on: cover property (switch_on_o == 2'h3);

  c_open_load: cover property (open_load_o != 2'h0);

endmodule // dsm_ctrl

// >>> dsm_host_model.sv
// Purpose: host controller model that samples the sense pin
// Assumes: sense settles a fixed number of cycles after turn-on
// Notes:   the host only reads here; the bench drives the enables

`timescale 1ns/1ps

module dsm_host_model #(
  parameter int unsigned SETTLE_CYCLES = 3
) (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                switch_on_i,
  input  wire logic                sense_oe_i,
  input  wire dsm_pkg::dsm_sense_t sense_output_i,
  output logic                     sample_valid_o,
  output dsm_pkg::dsm_sense_t      sample_o
);
  import dsm_pkg::*;

  logic [7:0] settle_cnt;

  // --------------------------------------------------
  // one reading per turn-on
  // --------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i || !switch_on_i) begin
      settle_cnt     <= 8'h00;
      sample_valid_o <= 1'b0;
    end else if (settle_cnt < 8'(SETTLE_CYCLES)) begin
      // an early reading is not trusted, even in short pwm on-times
      settle_cnt <= settle_cnt + 8'h01;
    end else if (!sample_valid_o) begin
      sample_valid_o <= sense_oe_i;
      sample_o       <= sense_output_i;
    end
  end
endmodule // dsm_host_model

// >>> dsm_ctrl_test.sv
// Purpose: self-checking bench of the switch mode control
// Assumes: inputs change on the falling clock edge
// Notes:   short timer counts keep the run small

`timescale 1ns/1ps
`include "dsm_regs.svh"

module dsm_ctrl_test;
  import dsm_pkg::*;

  localparam int STBY  = 8;
  localparam int RETRY = 4;

  logic       clk_i;
  logic       reset_i;
  logic       ce_i;
  logic       supply_ok;
  logic       gnd_ok;
  logic       en1;
  logic       en2;
  logic       diag;
  logic       latch;
  logic       sel_h;
  logic       sel_l;
  logic [1:0] therm;
  logic [1:0] ilim;
  logic [1:0] ol_det;
  logic [1:0] sw;
  logic [1:0] flt;
  logic [1:0] ol;
  logic       oe;
  logic       smp_vld;
  dsm_mode_t  mode;
  dsm_sense_t sense_output;
  dsm_sense_t smp;
  logic [7:0] rnd;
  int         idle;
  int         error_cnt;
  int         samples_checked;

  dsm_ctrl #(.STBY_CYCLES(STBY), .RETRY_CYCLES(RETRY)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .supply_ok_i(supply_ok), .gnd_ok_i(gnd_ok),
    .channel_one_enable_i(en1), .channel_two_enable_i(en2), .diagnostic_enable_i(diag),
    .latch_select_i(latch), .sense_select_high_i(sel_h), .sense_select_low_i(sel_l),
    .thermal_shutdown_i(therm), .current_limit_i(ilim), .open_load_detect_i(ol_det),
    .mode_o(mode), .switch_on_o(sw), .channel_fault_o(flt), .open_load_o(ol),
    .sense_output_o(sense_output), .sense_oe_o(oe)
  );

  dsm_host_model #(.SETTLE_CYCLES(3)) host (
    .clk_i(clk_i), .reset_i(reset_i), .switch_on_i(sw[0]), .sense_oe_i(oe),
    .sense_output_i(sense_output), .sample_valid_o(smp_vld), .sample_o(smp)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_clear(input int ch);
    int i;
    for (i = 0; i < 20 && flt[ch] !== 1'b0; i++) step(1);
    if (flt[ch] !== 1'b0) begin
      error_cnt++;
      $display("[FAIL] %0t fault never released", $time);
      give_verdict();
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic dsm_mode_t exp_mode(input logic [1:0] en, input logic d, input int idl);
    if (en != 2'h0) return DSM_ACTIVE;
    if (d) return DSM_DIAGNOSTIC;
    return (idl > STBY) ? DSM_STANDBY : DSM_STBY_DELAY;
  endfunction

  function automatic logic [3:0] exp_sns(input logic d, input logic [1:0] sel);
    if (!d) return {1'b0, DSM_SNS_HIZ};
    if (sel == `DSM_SEL_NONE) return {1'b0, DSM_SNS_NONE};
    if (sel == `DSM_SEL_CH1) return {1'b1, DSM_SNS_CH1_CUR};
    if (sel == `DSM_SEL_CH2) return {1'b1, DSM_SNS_CH2_CUR};
    return {1'b1, DSM_SNS_TEMP};
  endfunction

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    {reset_i, ce_i, gnd_ok, supply_ok} = 4'he;
    {en1, en2, diag, latch, sel_h, sel_l} = 6'h00;
    {therm, ilim, ol_det} = 6'h00;
    {rnd, idle, error_cnt, samples_checked} = {8'h4e, 32'd0, 32'd0, 32'd0};
    step(12);
    reset_i = 1'b0;
    step(2);
    check(mode, DSM_OFF, "unpowered mode");
    check(sw, 2'h0, "unpowered switch");
    $display("test power-up done");
    supply_ok = 1'b1;
    step(5);
    check(mode, DSM_STBY_DELAY, "delay entry");
    diag = 1'b1;
    step(1);
    check(mode, DSM_DIAGNOSTIC, "diag mode");
    check(sw, 2'h0, "diag switches");
    diag = 1'b0;
    step(7);
    check(mode, DSM_STBY_DELAY, "delay restart");
    step(4);
    check(mode, DSM_STANDBY, "standby");
    check({oe, sense_output}, {1'b0, DSM_SNS_HIZ}, "standby sense");
    $display("test standby done");
    ce_i = 1'b0;
    en1 = 1'b1;
    step(3);
    check(sw, 2'h0, "frozen");
    ce_i = 1'b1;
    step(1);
    check(mode, DSM_ACTIVE, "active");
    diag = 1'b1;
    step(1);
    check(sw, 2'h1, "diag in active");
    step(4);
    check({smp_vld, smp}, {1'b1, DSM_SNS_CH1_CUR}, "host reading");
    $display("test active done");
    en2 = 1'b1;
    therm = 2'h1;
    step(1);
    check(flt, 2'h1, "thermal fault");
    check(sw, 2'h2, "other channel");
    step(1);
    check({oe, sense_output}, {1'b1, DSM_SNS_FAULT}, "fault level");
    therm = 2'h0;
    latch = 1'b1;
    step(10);
    check(flt, 2'h1, "latched");
    latch = 1'b0;
    wait_clear(0);
    check(sw, 2'h3, "re-enable");
    ilim = 2'h2;
    step(1);
    check(flt, 2'h2, "limit fault");
    check(sw, 2'h1, "other channel");
    ilim = 2'h0;
    en2 = 1'b0;
    wait_clear(1);
    check(sw, 2'h1, "stays off");
    $display("test fault done");
    {gnd_ok, en2} = 2'h1;
    step(1);
    check(sw, 2'h0, "ground lost");
    gnd_ok = 1'b1;
    step(1);
    check(sw, 2'h3, "ground back");
    {en1, en2, ol_det} = 4'h2;
    step(1);
    check(ol, 2'h2, "open load");
    en2 = 1'b1;
    step(1);
    check(ol, 2'h0, "enable rise");
    en2 = 1'b0;
    step(1);
    check(ol, 2'h2, "open load again");
    diag = 1'b0;
    step(1);
    check(ol, 2'h0, "diag fall");
    check(oe, 1'b0, "sense floats");
    ol_det = 2'h0;
    supply_ok = 1'b0;
    step(1);
    check({mode, sw}, {DSM_OFF, 2'h0}, "supply lost");
    {supply_ok, en1} = 2'h3;
    step(2);
    $display("test ground and open load done");
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      {en1, en2, diag, sel_h, sel_l} = rnd[4:0];
      idle = (rnd[4:2] == 3'h0) ? idle + 1 : 0;
      step(1);
      check(sw, {en2, en1}, "random switch");
      check(mode, exp_mode({en2, en1}, diag, idle), "random mode");
      check({oe, sense_output}, exp_sns(diag, {sel_h, sel_l}), "random sense");
    end
    $display("test random done");
    give_verdict();
  end
endmodule // dsm_ctrl_test
